// file: core/scp_channel.sv
// serial channel pin functions, transfer engine and external clock capture
`timescale 1ns/100ps

module scp_channel import scp_pkg::*; #(
  parameter int BIT_CYC = 16
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_link_clock,
  input wire scp_cfg_s i_cfg,
  input wire scp_gpio_s i_gpio,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  input wire logic i_rx_take,
  input wire logic i_serial_in,
  input wire logic i_sclk_in,
  input wire logic i_hs_in,
  output scp_pins_s o_pins,
  output scp_pin_in_s o_port_in,
  output logic o_tx_ready,
  output logic [7:0] o_rx_data,
  output logic o_rx_valid
);

  // bit period counts
  localparam logic [DIV_W-1:0] BIT_END = DIV_W'(BIT_CYC - 1);
  localparam logic [DIV_W-1:0] HALF = DIV_W'(BIT_CYC / 2);

  scp_core_s s; // core state
  scp_core_s n; // core next state
  scp_link_s l; // link state
  scp_link_s next_l; // link next state

  logic asy; // asynchronous mode selected
  logic sync_m; // clock synchronous mode selected
  logic int_sync; // synchronous on internal clock
  logic ext_mode; // synchronous on external clock
  logic cts_ok; // transmit allowed by handshake
  logic can_tx; // buffered byte may start
  logic dummy; // receive-only transfer may start
  logic ext_edge; // active external clock edge
  logic rx_ok; // receiver allowed to store
  logic link_rst_n; // link logic cleared while external receive is off

  // link logic is held cleared while external receive is off, so each frame
  // starts on a fresh count although the link clock only runs inside frames;
  // switch external receive on or off only while the link clock is idle
  assign link_rst_n = i_arst_n && s.ext_en;

  // link domain: capture bits on the external clock
  always_comb begin
    next_l = l;
    // every link edge shifts one bit in
    next_l.sh = {i_serial_in, l.sh[7:1]};
    next_l.cnt = l.cnt + 3'h1;
    if (l.cnt == LINK_LAST) begin
      // word held until the next eight edges
      next_l.word = {i_serial_in, l.sh[7:1]};
      next_l.tgl = !l.tgl;
    end
  end

  // link domain register
  always_ff @(posedge i_link_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      l <= LINK_RST;
    end else begin
      l <= next_l;
    end
  end

  // core domain next state
  always_comb begin
    n = s;
    // pin and toggle synchronisers
    n.sin_s1 = i_serial_in;
    n.sin_s2 = s.sin_s1;
    n.ck_s1 = i_sclk_in;
    n.ck_s2 = s.ck_s1;
    n.ck_d = s.ck_s2;
    n.hs_s1 = i_hs_in;
    n.hs_s2 = s.hs_s1;
    n.dn_s1 = l.tgl;
    n.dn_s2 = s.dn_s1;
    n.dn_d = s.dn_s2;
    // pins readable as ports at all times
    n.pin_in.sin = s.sin_s2;
    n.pin_in.ck = s.ck_s2;
    n.pin_in.hs = s.hs_s2;

    // mode decode
    asy = (i_cfg.mode == SCP_ASYNC7) || (i_cfg.mode == SCP_ASYNC8)
      || (i_cfg.mode == SCP_ASYNC9);
    sync_m = (i_cfg.mode == SCP_SYNC);
    int_sync = sync_m && !i_cfg.ck_src;
    ext_mode = sync_m && i_cfg.ck_src && !i_cfg.ck_dir;
    // clear-to-send low allows a start
    cts_ok = i_cfg.fc_dis || i_cfg.fc_sel || i_cfg.hs_dir
      || !s.hs_s2;
    can_tx = s.tb_full && i_cfg.tx_en && cts_ok;
    dummy = sync_m && i_cfg.rx_en && !i_cfg.tx_en && !s.rx_full;
    // sampling edge of the polarity-adjusted external clock
    ext_edge = !(s.ck_d ^ i_cfg.ck_pol)
      && (s.ck_s2 ^ i_cfg.ck_pol);
    // receive needs the input pin set as input
    rx_ok = i_cfg.rx_en && !i_cfg.in_dir;
    n.ext_en = ext_mode && rx_ok;

    // cpu loads the transmit buffer
    if (i_tx_valid && !s.tb_full) begin
      n.tb = i_tx_data;
      n.tb_full = 1'b1;
    end
    // cpu takes the received byte
    if (i_rx_take) begin
      n.rx_full = 1'b0;
    end
    // byte finished in the link domain; set wins over take; a toggle from
    // clearing the link logic arrives while external receive is off
    if (s.ext_en && (s.dn_s2 != s.dn_d)) begin
      n.rx_data = l.word;
      n.rx_full = 1'b1;
    end

    // transfer engine
    case (s.st)
      SCP_IDLE: begin
        n.sclk = 1'b1;
        if (asy && can_tx) begin
          n.sh = {STOP_LVL, s.tb, START_LVL};
          n.bits = FRAME_BITS;
          n.div = BIT_END;
          n.tb_full = 1'b0;
          n.st = SCP_ASY;
        end else if ((int_sync || ext_mode) && (can_tx || dummy)) begin
          // receive only shifts dummy ones out
          n.sh = {SYNC_FILL, can_tx ? s.tb : DUMMY_BYTE};
          n.tb_full = s.tb_full && !can_tx;
          n.bits = SYNC_BITS;
          n.div = BIT_END;
          n.sclk = 1'b0;
          n.st = ext_mode ? SCP_EXT : SCP_INT;
        end
      end
      SCP_INT: begin
        // clock low first half, high second half
        n.div = s.div - 1'b1;
        n.sclk = (s.div <= HALF);
        if (s.div == HALF) begin
          n.rx_sh = {s.sin_s2, s.rx_sh[7:1]};
        end
        if (s.div == '0) begin
          n.sh = {STOP_LVL, s.sh[9:1]};
          n.bits = s.bits - 1'b1;
          n.div = BIT_END;
          n.sclk = 1'b0;
          if (s.bits == LAST_BIT) begin
            n.st = SCP_IDLE;
            n.sclk = 1'b1;
            if (rx_ok) begin
              n.rx_data = s.rx_sh;
              n.rx_full = 1'b1;
            end
          end
        end
      end
      SCP_ASY: begin
        n.div = s.div - 1'b1;
        if (s.div == '0) begin
          n.sh = {STOP_LVL, s.sh[9:1]};
          n.bits = s.bits - 1'b1;
          n.div = BIT_END;
          if (s.bits == LAST_BIT) begin
            n.st = SCP_IDLE;
          end
        end
      end
      SCP_EXT: begin
        // next bit follows each sampling edge
        if (ext_edge) begin
          n.sh = {STOP_LVL, s.sh[9:1]};
          n.bits = s.bits - 1'b1;
          if (s.bits == LAST_BIT) begin
            n.st = SCP_IDLE;
          end
        end
        if (!ext_mode) begin
          n.st = SCP_IDLE;
        end
      end
      default: begin
        n.st = SCP_IDLE;
      end
    endcase

    // asynchronous receiver
    if (!s.rx_on) begin
      if (asy && rx_ok && !s.sin_s2) begin
        // start bit seen, sample at mid-bit
        n.rx_on = 1'b1;
        n.rx_div = HALF;
        n.rx_bits = FRAME_BITS;
      end
    end else begin
      n.rx_div = s.rx_div - 1'b1;
      if (s.rx_div == '0) begin
        n.rx_div = BIT_END;
        n.rx_bits = s.rx_bits - 1'b1;
        if (s.rx_bits == LAST_BIT) begin
          // stop bit reached, store the byte
          n.rx_on = 1'b0;
          n.rx_data = s.rx_sh;
          n.rx_full = 1'b1;
        end else begin
          n.rx_sh = {s.sin_s2, s.rx_sh[7:1]};
        end
      end
      if (!asy || !rx_ok) begin
        n.rx_on = 1'b0;
      end
    end

    // disabled mode empties both buffers and stops transfers
    if (i_cfg.mode == SCP_OFF) begin
      n.st = SCP_IDLE;
      n.tb_full = 1'b0;
      n.rx_full = 1'b0;
      n.rx_on = 1'b0;
      n.sclk = 1'b1;
    end
    n.tx_ready = !n.tb_full;

    // serial data output pin
    if (i_cfg.mode == SCP_OFF) begin
      n.pins.sout = LINE_IDLE;
      n.pins.sout_oe = 1'b0;
    end else begin
      // idle line high until a transfer starts
      n.pins.sout = (n.st == SCP_IDLE) ? LINE_IDLE : n.sh[0];
      // open drain only pulls low
      n.pins.sout_oe = !i_cfg.od || !n.pins.sout;
    end

    // clock pin
    if (int_sync) begin
      n.pins.ck = n.sclk ^ i_cfg.ck_pol;
      n.pins.ck_oe = 1'b1;
    end else if (ext_mode) begin
      n.pins.ck = i_gpio.ck;
      n.pins.ck_oe = 1'b0;
    end else begin
      // released as a general port
      n.pins.ck = i_gpio.ck;
      n.pins.ck_oe = i_cfg.ck_dir;
    end

    // handshake pin
    if (i_cfg.fc_dis) begin
      n.pins.hs = i_gpio.hs;
      n.pins.hs_oe = i_cfg.hs_dir;
    end else if (i_cfg.fc_sel) begin
      // low while a byte can be accepted
      n.pins.hs = !(i_cfg.rx_en && !n.rx_full);
      n.pins.hs_oe = 1'b1;
    end else if (!i_cfg.hs_dir) begin
      n.pins.hs = i_gpio.hs;
      n.pins.hs_oe = 1'b0;
    end else begin
      n.pins.hs = i_gpio.hs;
      n.pins.hs_oe = 1'b1;
    end
  end

  // core domain register
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= CORE_RST;
    end else begin
      s <= n;
    end
  end

  // outputs straight from flops
  assign o_pins = s.pins;
  assign o_port_in = s.pin_in;
  assign o_tx_ready = s.tx_ready;
  assign o_rx_data = s.rx_data;
  assign o_rx_valid = s.rx_full;

endmodule

// file: core/scp_pkg.sv
// package: constants and carriers for the serial channel pin block
package scp_pkg;

  // serial mode field codes
  typedef enum logic [2:0] {
    SCP_OFF = 3'b000,
    SCP_SYNC = 3'b001,
    SCP_ASYNC7 = 3'b100,
    SCP_ASYNC8 = 3'b101,
    SCP_ASYNC9 = 3'b110
  } scp_mode_e;

  // transfer engine states
  typedef enum logic [1:0] {
    SCP_IDLE = 2'b00,
    SCP_INT = 2'b01,
    SCP_ASY = 2'b10,
    SCP_EXT = 2'b11
  } scp_st_e;

  localparam int DIV_W = 16;
  localparam logic [3:0] FRAME_BITS = 4'ha;
  localparam logic [3:0] SYNC_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h1;
  localparam logic [7:0] DUMMY_BYTE = 8'hff;
  localparam logic LINE_IDLE = 1'h1;
  localparam logic START_LVL = 1'h0;
  localparam logic STOP_LVL = 1'h1;
  localparam logic [1:0] SYNC_FILL = 2'h3;

  // cpu-side configuration bits
  typedef struct packed {
    scp_mode_e mode;
    logic rx_en;
    logic tx_en;
    logic ck_pol;
    logic ck_src;
    logic fc_dis;
    logic fc_sel;
    logic od;
    logic in_dir;
    logic ck_dir;
    logic hs_dir;
  } scp_cfg_s;

  // general port output values for released pins
  typedef struct packed {
    logic ck;
    logic hs;
  } scp_gpio_s;

  // synchronised pin levels
  typedef struct packed {
    logic sin;
    logic ck;
    logic hs;
  } scp_pin_in_s;

  // pin drive: value and output enable
  typedef struct packed {
    logic sout;
    logic sout_oe;
    logic ck;
    logic ck_oe;
    logic hs;
    logic hs_oe;
  } scp_pins_s;

  // core domain state
  typedef struct packed {
    logic sin_s1;
    logic sin_s2;
    logic ck_s1;
    logic ck_s2;
    logic ck_d;
    logic hs_s1;
    logic hs_s2;
    logic dn_s1;
    logic dn_s2;
    logic dn_d;
    logic ext_en;
    scp_st_e st;
    logic [3:0] bits;
    logic [DIV_W-1:0] div;
    logic [9:0] sh;
    logic sclk;
    logic [7:0] tb;
    logic tb_full;
    logic tx_ready;
    logic rx_on;
    logic [3:0] rx_bits;
    logic [DIV_W-1:0] rx_div;
    logic [7:0] rx_sh;
    logic [7:0] rx_data;
    logic rx_full;
    scp_pins_s pins;
    scp_pin_in_s pin_in;
  } scp_core_s;

  // link domain state
  typedef struct packed {
    logic [7:0] sh;
    logic [2:0] cnt;
    logic [7:0] word;
    logic tgl;
  } scp_link_s;

  localparam scp_core_s CORE_RST = '0;
  localparam scp_link_s LINK_RST = '0;
  localparam logic [2:0] LINK_LAST = 3'h7;

endpackage

// file: sim/scp_channel_monitor.sv
// assertion checker for the serial channel pin block
`timescale 1ns/100ps
module scp_chk import scp_pkg::*; #(
  parameter int BIT_CYC = 16
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire scp_cfg_s i_cfg,
  input wire scp_gpio_s i_gpio,
  input wire logic i_tx_valid,
  input wire logic i_serial_in,
  input wire scp_pins_s o_pins,
  input wire scp_pin_in_s o_port_in,
  input wire logic o_tx_ready,
  input wire logic o_rx_valid
);
  scp_cfg_s pc; // last sampled config
  scp_gpio_s pg; // last sampled port values
  logic [1:0] q; // settled cycle count
  logic s; // config held for five samples
  // count cycles with unchanged configuration
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pc <= '0;
      pg <= '0;
      q <= '0;
    end else begin
      pc <= i_cfg;
      pg <= i_gpio;
      q <= (i_cfg != pc || i_gpio != pg) ? 2'h0 : (q == 2'h3 ? q : q + 2'h1);
    end
  end
  assign s = q == 2'h3 && i_cfg == pc && i_gpio == pg;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  AST_HS_PORT: assert property (s && i_cfg.fc_dis |-> o_pins.hs_oe == i_cfg.hs_dir
    && (!i_cfg.hs_dir || o_pins.hs == i_gpio.hs)) else $error("handshake pin not a port");
  AST_RTS: assert property (s && !i_cfg.fc_dis && i_cfg.fc_sel |-> o_pins.hs_oe)
    else $error("request output not driven");
  AST_CTS: assert property (s && !i_cfg.fc_dis && !i_cfg.fc_sel && !i_cfg.hs_dir
    |-> !o_pins.hs_oe) else $error("clear input driven");
  AST_CK_PORT: assert property (s && !i_cfg.ck_src && i_cfg.mode != SCP_SYNC
    |-> o_pins.ck_oe == i_cfg.ck_dir) else $error("clock pin not a port");
  AST_CK_EXT: assert property (s && i_cfg.ck_src && !i_cfg.ck_dir && i_cfg.mode == SCP_SYNC
    |-> !o_pins.ck_oe) else $error("external clock pin driven");
  AST_OD: assert property (s && i_cfg.od && o_pins.sout |-> !o_pins.sout_oe)
    else $error("open drain drives high");
  AST_ASY_DRV: assert property (s && !i_cfg.od && i_cfg.mode[2] |-> o_pins.sout_oe)
    else $error("async output not driven");
  AST_RX_ONLY: assert property (s && i_cfg.mode == SCP_SYNC && i_cfg.rx_en && !i_cfg.tx_en
    && !i_cfg.ck_src && !o_rx_valid |-> ##[1:40] ($changed(o_pins.ck) || o_rx_valid))
    else $error("receive only stopped clocking");
  AST_PIN_IN: assert property (s |-> o_port_in.sin == $past(i_serial_in, 3))
    else $error("input level not passed to port");
  AST_TX_TAKE: assert property (i_cfg.mode[2] && i_tx_valid && o_tx_ready |=> !o_tx_ready)
    else $error("byte not taken");
endmodule
bind scp_channel scp_chk #(.BIT_CYC(BIT_CYC)) u_scp_chk (.i_clock, .i_arst_n, .i_cfg,
  .i_gpio, .i_tx_valid, .i_serial_in, .o_pins, .o_port_in, .o_tx_ready, .o_rx_valid);

// file: sim/scp_channel_tb_top.sv
// testbench for the serial channel pin block
`timescale 1ns/100ps
module scp_channel_tb_top import scp_pkg::*;;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic lk, sd, txv, take, run, hs_in;
  logic [7:0] txd;
  scp_cfg_s cfg, nc;
  scp_gpio_s gpio;
  scp_pins_s pins;
  scp_pin_in_s pin_in;
  logic tx_rdy, rx_v;
  logic [7:0] rx_d;
  int miscompares = 0;
  int n_compared = 0;
  int i, n;
  logic [9:0] f;
  always #10 clk = !clk;
  scp_channel #(.BIT_CYC(4)) u_scp_channel (.i_clock(clk), .i_arst_n(rst_n),
    .i_link_clock(lk), .i_cfg(cfg), .i_gpio(gpio), .i_tx_data(txd), .i_tx_valid(txv),
    .i_rx_take(take), .i_serial_in(sd), .i_sclk_in(lk), .i_hs_in(hs_in), .o_pins(pins),
    .o_port_in(pin_in), .o_tx_ready(tx_rdy), .o_rx_data(rx_d), .o_rx_valid(rx_v));
  scp_remote u_scp_remote (.i_run(run), .i_byte(8'hc3), .o_clk(lk), .o_data(sd));
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic results;
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // load config and let it settle
  task automatic apply;
    @(posedge clk) cfg <= nc;
    repeat (6) @(negedge clk);
  endtask
  // one-cycle pulse on a control input
  task automatic pulse(input int w);
    @(posedge clk) if (w == 0) txv <= 1'h1; else if (w == 1) take <= 1'h1; else run <= 1'h1;
    @(posedge clk) {txv, take, run} <= 3'h0;
  endtask
  // wait for a level, bounded
  task automatic await(input int w);
    for (i = 0; i < 400 && (w ? rx_v : tx_rdy) !== 1'h1; i++) @(negedge clk);
    if (i == 400) begin
      miscompares++;
      results();
    end
  endtask
  // send a byte and sample the frame mid-bit
  task automatic send(input logic [7:0] b);
    await(0);
    @(posedge clk) txd <= b;
    pulse(0);
    repeat (3) @(negedge clk);
    for (n = 0; n < 10; n++) begin
      f[n] = pins.sout;
      repeat (4) @(negedge clk);
    end
    chk(f, {1'h1, b, 1'h0});
  endtask
  initial begin
    {txv, take, run, hs_in, txd} = '0;
    cfg = '0;
    gpio = 2'h2;
    nc = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    {nc.tx_en, nc.fc_dis, nc.hs_dir, nc.ck_dir} = 4'hf;
    nc.mode = SCP_ASYNC8;
    apply();
    chk({pins.sout, pins.sout_oe}, 2'h3);
    chk({pins.hs_oe, pins.hs}, 2'h2);
    chk({pins.ck_oe, pins.ck}, 2'h3);
    chk({pin_in.ck, pin_in.hs}, 2'h0);
    send(8'h5a);
    send(8'ha5);
    nc.od = 1'h1;
    apply();
    chk(pins.sout_oe, 1'h0);
    chk(pin_in.sin, 1'h1);
    {nc.fc_dis, nc.fc_sel} = 2'h1;
    apply();
    chk({pins.hs_oe, pins.hs}, 2'h3);
    {nc.fc_sel, nc.hs_dir} = 2'h0;
    apply();
    chk(pins.hs_oe, 1'h0);
    {nc.od, nc.tx_en, nc.rx_en} = 3'h1;
    nc.mode = SCP_SYNC;
    apply();
    chk(pins.sout_oe, 1'h1);
    n = 0;
    for (i = 0; i < 16; i++) begin
      f[0] = pins.ck;
      @(negedge clk);
      n += int'(f[0] !== pins.ck);
    end
    chk(n != 0, 1'h1);
    pulse(0);
    await(1);
    chk(tx_rdy, 1'h0);
    chk(pins.ck, 1'h1);
    nc.ck_pol = 1'h1;
    apply();
    chk(pins.ck, 1'h0);
    {nc.ck_pol, nc.rx_en} = 2'h0;
    apply();
    nc.mode = SCP_OFF;
    apply();
    chk(rx_v, 1'h0);
    nc.mode = SCP_SYNC;
    apply();
    nc.rx_en = 1'h1;
    apply();
    chk(tx_rdy, 1'h1);
    {nc.ck_src, nc.ck_dir} = 2'h2;
    apply();
    chk(pins.ck_oe, 1'h0);
    pulse(2);
    repeat (40) @(negedge clk);
    pulse(1);
    pulse(2);
    await(1);
    chk(rx_d, 8'hc3);
    results();
  end
endmodule

// file: sim/scp_remote.sv
// remote serial device: clocks out one byte per run pulse
`timescale 1ns/100ps
module scp_remote (
  input wire logic i_run,
  input wire logic [7:0] i_byte,
  output logic o_clk,
  output logic o_data
);
  int k;
  // clock stands low outside frames; data set ahead of each rising edge
  initial begin
    o_clk = 1'h0;
    o_data = 1'h1;
    forever begin
      @(posedge i_run);
      #5; // off the core clock edges, so pin samples never race
      for (k = 0; k < 8; k++) begin
        o_data = i_byte[k];
        #40 o_clk = 1'h1;
        #40 o_clk = 1'h0;
      end
      o_data = !o_data; // released line shows no stale bit
    end
  end
endmodule
